//--- design/uied_pkg.sv
// Constants and carrier types for the input endpoint descriptor registers.
package uied_pkg;

    // ------------------------------------------------------------
    // Bus and field widths
    // ------------------------------------------------------------
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int IDX_W = 7;
    localparam int EP_W = 2;

    // ------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------
    localparam logic [15:0] EP0_IN_CONFIG_ADDR = 16'hFF80;
    localparam logic [15:0] EP0_IN_COUNT_ADDR = 16'hFF81;
    localparam logic [15:0] EP0_OUT_CONFIG_ADDR = 16'hFF82;
    localparam logic [15:0] EP0_OUT_COUNT_ADDR = 16'hFF83;
    localparam logic [15:0] IRQ_STATUS_ADDR = 16'hFF88;
    localparam logic [15:0] IRQ_ENABLE_ADDR = 16'hFF89;
    localparam logic [15:0] IRQ_CLEAR_ADDR = 16'hFF8A;
    localparam logic [15:0] EPN_WINDOW_ADDR = 16'hFF00;

    // ------------------------------------------------------------
    // Field slots inside one endpoint window of eight bytes
    // ------------------------------------------------------------
    localparam logic [2:0] FLD_X_COUNT = 3'h0;
    localparam logic [2:0] FLD_X_BASE = 3'h1;
    localparam logic [2:0] FLD_Y_BASE = 3'h2;
    localparam logic [2:0] FLD_Y_COUNT = 3'h3;
    localparam logic [2:0] FLD_SIZE = 3'h4;
    localparam logic [2:0] FLD_MODE = 3'h5;

    // ------------------------------------------------------------
    // Bit positions, shared by endpoint 0 and endpoints 1 to 3 except stall (endpoint 0) and double buffer enable (1 to 3)
    // ------------------------------------------------------------
    localparam int BIT_NAK = 7;
    localparam int BIT_USE_EN = 7;
    localparam int BIT_TOGGLE = 5;
    localparam int BIT_DOUBLE_BUFFER_ENABLE = 4;
    localparam int BIT_STALL = 3;
    localparam int BIT_IRQ_EN = 2;

    // ------------------------------------------------------------
    // Write masks and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] EP0_CONFIG_WMASK = 8'h8C;
    localparam logic [7:0] EP0_COUNT_WMASK = 8'h8F;
    localparam logic [7:0] SIZE_WMASK = 8'h7F;
    localparam logic [7:0] MODE_WMASK = 8'h94;
    localparam logic [7:0] CONFIG_RST = 8'h00;
    localparam logic [7:0] COUNT_RST = 8'h80;
    localparam logic [7:0] FIELD_RST = 8'h00;

    // ------------------------------------------------------------
    // Buffer addresses and byte limits
    // ------------------------------------------------------------
    localparam logic [15:0] EP0_IN_BUF_ADDR = 16'hFEF8;
    localparam logic [15:0] EP0_OUT_BUF_ADDR = 16'hFEF0;
    localparam logic [6:0] EP0_BUF_BYTES = 7'h08;
    localparam logic [6:0] MAX_BYTES = 7'h40;

    // ------------------------------------------------------------
    // Buffer manager carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [EP_W-1:0] ep;
        logic [IDX_W-1:0] idx;
        logic done;
        logic setup;
    } uied_req_type;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [ADDR_W-1:0] out_base;
        logic [IDX_W-1:0] count;
        logic count_ok;
        logic nak;
        logic stall;
        logic enable;
        logic in_range;
    } uied_ans_type;

endpackage

//--- design/uied_descriptors.sv
// Input endpoint descriptor registers with buffer manager lookup.
`timescale 1ns/1ps

// Function
// - Byte counts of endpoints 1 to 3 are 7 bits holding 0 to 64, endpoint 0 counts are 4 bits, and values above 64 are undefined.
// - Count bit 7 set means the buffer is empty and IN requests get NAK.
// - A buffer start address is the 8-bit base followed by three zero bits.
// - Every transaction on a buffer starts at its programmed base.
// - Completing a transaction never alters the base address field.
// - One 7-bit size field serves both X and Y buffers and bit 7 is reserved.
// - Endpoint 0 uses four fixed registers at FF80 to FF83.
// - Endpoint 0 data sits at fixed buffers FEF8 for input and FEF0 for output.
// - Endpoint 0 fields keep the bit positions of endpoints 1 to 3.
// - Endpoint 0 completion raises an interrupt only when its enable is set.
// - Software sets the endpoint 0 input stall and a SETUP clears it, unless FF80 is written in the same cycle.
// - The endpoint 0 toggle bit is read-only and tracks DATA0 and DATA1.
// - Endpoint 0 input is served only while its use enable bit is set.
// - Without double buffering only X is used, else the toggle picks X or Y.
module uied_descriptors #(
    parameter int EP_COUNT = 3
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic [uied_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [uied_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [uied_pkg::DATA_W-1:0] reg_rdata,
    input wire uied_pkg::uied_req_type bm_req,
    output uied_pkg::uied_ans_type bm_ans,
    output logic irq
);
    import uied_pkg::*;

    if (EP_COUNT < 1 || EP_COUNT > 3) begin : g_bad_count
        $error("EP_COUNT must lie between 1 and 3.");
    end

    localparam logic [1:0] EP_LIMIT = 2'(EP_COUNT);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [7:0] in_ep_x_count [EP_COUNT];
    logic [7:0] in_ep_x_base [EP_COUNT];
    logic [7:0] in_ep_y_base [EP_COUNT];
    logic [7:0] in_ep_y_count [EP_COUNT];
    logic [7:0] in_ep_buffer_size [EP_COUNT];
    logic [7:0] in_ep_mode [EP_COUNT];
    logic [7:0] ep0_in_config;
    logic [7:0] ep0_in_byte_count;
    logic [7:0] ep0_out_config;
    logic [7:0] ep0_out_byte_count;
    logic [EP_COUNT:0] irq_status;
    logic [EP_COUNT:0] irq_enable;

    // ------------------------------------------------------------
    // Address decoding
    // ------------------------------------------------------------
    // fixed endpoint 0 map.
    wire hit_in_cfg = reg_addr == EP0_IN_CONFIG_ADDR;
    wire hit_in_cnt = reg_addr == EP0_IN_COUNT_ADDR;
    wire hit_out_cfg = reg_addr == EP0_OUT_CONFIG_ADDR;
    wire hit_out_cnt = reg_addr == EP0_OUT_COUNT_ADDR;
    wire hit_status = reg_addr == IRQ_STATUS_ADDR;
    wire hit_enable = reg_addr == IRQ_ENABLE_ADDR;
    wire hit_clear = reg_addr == IRQ_CLEAR_ADDR;
    wire [1:0] slot = reg_addr[4:3];
    wire [2:0] fld = reg_addr[2:0];
    wire hit_epn = reg_addr[15:5] == EPN_WINDOW_ADDR[15:5] &&
        slot < EP_LIMIT;
    wire wr_in_cfg = reg_wr && hit_in_cfg;
    wire wr_in_cnt = reg_wr && hit_in_cnt;

    // ------------------------------------------------------------
    // Buffer manager events
    // ------------------------------------------------------------
    wire done_ep0 = bm_req.done && bm_req.ep == 2'h0;
    logic [EP_COUNT-1:0] done_epn;
    logic [EP_COUNT-1:0] use_y;
    logic [EP_COUNT:0] irq_set;
    wire [EP_COUNT:0] irq_clear = (reg_wr && hit_clear) ?
        reg_wdata[EP_COUNT:0] : '0;

    // endpoint 0 completion counts only with its enable set.
    assign irq_set[0] = done_ep0 && ep0_in_config[BIT_IRQ_EN];

    for (genvar g = 0; g < EP_COUNT; g++) begin : g_ev
        assign done_epn[g] = bm_req.done && bm_req.ep == 2'(g + 1);
        // toggle picks Y only under double buffering.
        assign use_y[g] = in_ep_mode[g][BIT_DOUBLE_BUFFER_ENABLE] &&
            in_ep_mode[g][BIT_TOGGLE];
        assign irq_set[g+1] = done_epn[g] && in_ep_mode[g][BIT_IRQ_EN];
    end

    // ------------------------------------------------------------
    // Endpoint 1 to 3 descriptors
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        for (int i = 0; i < EP_COUNT; i++) begin
            if (srst) begin
                in_ep_x_count[i] <= COUNT_RST;
                in_ep_x_base[i] <= FIELD_RST;
                in_ep_y_base[i] <= FIELD_RST;
                in_ep_y_count[i] <= COUNT_RST;
                in_ep_buffer_size[i] <= FIELD_RST;
                in_ep_mode[i] <= CONFIG_RST;
            end else begin
                if (reg_wr && hit_epn && slot == 2'(i)) begin
                    if (fld == FLD_X_COUNT) begin
                        in_ep_x_count[i] <= reg_wdata;
                    end else if (fld == FLD_X_BASE) begin
                        in_ep_x_base[i] <= reg_wdata;
                    end else if (fld == FLD_Y_BASE) begin
                        in_ep_y_base[i] <= reg_wdata;
                    end else if (fld == FLD_Y_COUNT) begin
                        in_ep_y_count[i] <= reg_wdata;
                    end else if (fld == FLD_SIZE) begin
                        in_ep_buffer_size[i] <= reg_wdata & SIZE_WMASK;
                    end else if (fld == FLD_MODE) begin
                        in_ep_mode[i] <= (reg_wdata & MODE_WMASK) |
                            (in_ep_mode[i] & ~MODE_WMASK);
                    end
                end
                // completion hands the used buffer back as empty.
                if (done_epn[i]) begin
                    if (use_y[i]) begin
                        in_ep_y_count[i][BIT_NAK] <= 1'b1;
                    end else begin
                        in_ep_x_count[i][BIT_NAK] <= 1'b1;
                    end
                    in_ep_mode[i][BIT_TOGGLE] <= ~in_ep_mode[i][BIT_TOGGLE];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Endpoint 0 descriptors
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ep0_in_config <= CONFIG_RST;
            ep0_in_byte_count <= COUNT_RST;
            ep0_out_config <= CONFIG_RST;
            ep0_out_byte_count <= COUNT_RST;
        end else begin
            // same field positions as the other endpoints.
            if (wr_in_cfg) begin
                ep0_in_config <= (reg_wdata & EP0_CONFIG_WMASK) |
                    (ep0_in_config & ~EP0_CONFIG_WMASK);
            end else if (bm_req.setup) begin
                ep0_in_config[BIT_STALL] <= 1'b0;
            end
            if (done_ep0) begin
                ep0_in_config[BIT_TOGGLE] <= ~ep0_in_config[BIT_TOGGLE];
            end
            if (wr_in_cnt) begin
                ep0_in_byte_count <= reg_wdata & EP0_COUNT_WMASK;
            end
            if (done_ep0) begin
                ep0_in_byte_count[BIT_NAK] <= 1'b1;
            end
            if (reg_wr && hit_out_cfg) begin
                ep0_out_config <= reg_wdata & EP0_CONFIG_WMASK;
            end
            if (reg_wr && hit_out_cnt) begin
                ep0_out_byte_count <= reg_wdata & EP0_COUNT_WMASK;
            end
        end
    end

    // ------------------------------------------------------------
    // Interrupt status, enable and output
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            irq_status <= '0;
            irq_enable <= '0;
            irq <= 1'b0;
        end else begin
            irq_status <= (irq_status & ~irq_clear) | irq_set;
            if (reg_wr && hit_enable) begin
                irq_enable <= reg_wdata[EP_COUNT:0];
            end
            irq <= |(irq_status & irq_enable);
        end
    end

    // ------------------------------------------------------------
    // Register read path
    // ------------------------------------------------------------
    logic [7:0] next_rdata;
    always_comb begin
        next_rdata = 8'h00;
        if (hit_in_cfg) begin
            next_rdata = ep0_in_config;
        end else if (hit_in_cnt) begin
            next_rdata = ep0_in_byte_count;
        end else if (hit_out_cfg) begin
            next_rdata = ep0_out_config;
        end else if (hit_out_cnt) begin
            next_rdata = ep0_out_byte_count;
        end else if (hit_status) begin
            next_rdata = 8'(irq_status);
        end else if (hit_enable) begin
            next_rdata = 8'(irq_enable);
        end else if (hit_epn) begin
            if (fld == FLD_X_COUNT) begin
                next_rdata = in_ep_x_count[slot];
            end else if (fld == FLD_X_BASE) begin
                next_rdata = in_ep_x_base[slot];
            end else if (fld == FLD_Y_BASE) begin
                next_rdata = in_ep_y_base[slot];
            end else if (fld == FLD_Y_COUNT) begin
                next_rdata = in_ep_y_count[slot];
            end else if (fld == FLD_SIZE) begin
                next_rdata = in_ep_buffer_size[slot];
            end else if (fld == FLD_MODE) begin
                next_rdata = in_ep_mode[slot];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= reg_rd ? next_rdata : 8'h00;
        end
    end

    // ------------------------------------------------------------
    // Buffer manager lookup
    // ------------------------------------------------------------
    wire [1:0] sel_raw = bm_req.ep - 2'h1;
    wire [1:0] sel = (sel_raw < EP_LIMIT) ? sel_raw : 2'h0;
    wire sel_ok = bm_req.ep != 2'h0 && sel_raw < EP_LIMIT;
    // base field with three zero low bits.
    wire [7:0] sel_base = use_y[sel] ? in_ep_y_base[sel] : in_ep_x_base[sel];
    wire [15:0] sel_start = {5'h00, sel_base, 3'h0};
    wire [7:0] sel_count = use_y[sel] ? in_ep_y_count[sel] :
        in_ep_x_count[sel];

    uied_ans_type next_ans;
    always_comb begin
        next_ans = '0;
        next_ans.out_base = EP0_OUT_BUF_ADDR;
        if (bm_req.ep == 2'h0) begin
            next_ans.addr = EP0_IN_BUF_ADDR + 16'(bm_req.idx);
            next_ans.count = {3'h0, ep0_in_byte_count[3:0]};
            next_ans.nak = ep0_in_byte_count[BIT_NAK];
            next_ans.stall = ep0_in_config[BIT_STALL];
            next_ans.enable = ep0_in_config[BIT_USE_EN];
            next_ans.in_range = bm_req.idx < EP0_BUF_BYTES;
        end else begin
            // start from programmed base plus k.
            next_ans.addr = sel_start + 16'(bm_req.idx);
            next_ans.count = sel_count[6:0];
            next_ans.nak = sel_count[BIT_NAK];
            next_ans.enable = sel_ok && in_ep_mode[sel][BIT_USE_EN];
            next_ans.in_range = bm_req.idx < in_ep_buffer_size[sel][6:0];
        end
        next_ans.count_ok = next_ans.count <= MAX_BYTES;
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            bm_ans <= '0;
        end else begin
            bm_ans <= next_ans;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    nak_on_done_a: assert property (
        done_ep0 |=> ep0_in_byte_count[BIT_NAK])
        else $error("Endpoint 0 count not empty after completion.");

    stall_clear_a: assert property (
        bm_req.setup && !wr_in_cfg |=> !ep0_in_config[BIT_STALL])
        else $error("Stall survived a SETUP.");

    toggle_flip_a: assert property (
        done_ep0 |=> ep0_in_config[BIT_TOGGLE] !=
            $past(ep0_in_config[BIT_TOGGLE]))
        else $error("Endpoint 0 toggle did not flip.");

    irq_gate_a: assert property (
        done_ep0 && !ep0_in_config[BIT_IRQ_EN] && !irq_status[0]
        |=> !irq_status[0])
        else $error("Interrupt raised with enable clear.");

    ep0_addr_a: assert property (
        bm_req.ep == 2'h0 |=> bm_ans.addr ==
            EP0_IN_BUF_ADDR + 16'($past(bm_req.idx)))
        else $error("Endpoint 0 buffer address wrong.");

    base_keep_a: assert property (
        bm_req.done && !reg_wr |=> $stable(in_ep_y_base[0]) &&
            $stable(in_ep_x_base[0]))
        else $error("Base changed by completion.");

    size_rsv_a: assert property (
        !in_ep_buffer_size[0][7])
        else $error("Size reserved bit set.");

    use_gate_a: assert property (
        bm_req.ep == 2'h0 && !ep0_in_config[BIT_USE_EN]
        |=> !bm_ans.enable)
        else $error("Endpoint 0 served while disabled.");

    map_read_a: assert property (
        reg_rd && hit_in_cnt |=> reg_rdata == $past(ep0_in_byte_count))
        else $error("Endpoint 0 count read wrong.");

    x_only_a: assert property (
        bm_req.ep == 2'h1 && !in_ep_mode[0][BIT_DOUBLE_BUFFER_ENABLE]
        |=> bm_ans.addr == {5'h00, $past(in_ep_x_base[0]), 3'h0} +
            16'($past(bm_req.idx)))
        else $error("Y buffer used without double buffering.");

    irq_level_a: assert property (
        ##1 irq == $past(|(irq_status & irq_enable)))
        else $error("Interrupt output does not follow status.");

    done_cov: cover property (done_ep0 && ep0_in_config[BIT_IRQ_EN]);
    setup_cov: cover property (bm_req.setup && ep0_in_config[BIT_STALL]);
    ybuf_cov: cover property (bm_req.done && use_y[0]);
    irq_cov: cover property (irq);

endmodule

//--- testbench/uied_bm_model.sv
// Behavioural buffer manager that drives lookups and completions.
`timescale 1ns/1ps
module uied_bm_model (
    input wire logic ref_clk,
    output uied_pkg::uied_req_type bm_req
);
    import uied_pkg::*;

    initial begin
        bm_req = '0;
    end

    task automatic serve(input logic [1:0] ep, input logic [6:0] idx);
        @(posedge ref_clk);
        bm_req.ep <= ep;
        bm_req.idx <= idx;
        @(posedge ref_clk);
        #1;
    endtask

    task automatic pulse_done();
        @(posedge ref_clk);
        bm_req.done <= 1'b1;
        @(posedge ref_clk);
        bm_req.done <= 1'b0;
    endtask

    task automatic pulse_setup();
        @(posedge ref_clk);
        bm_req.setup <= 1'b1;
        @(posedge ref_clk);
        bm_req.setup <= 1'b0;
    endtask
endmodule

//--- testbench/usb_in_endpoint_descriptors_bench.sv
// Self-checking bench for the input endpoint descriptor registers.
`timescale 1ns/1ps
module usb_in_endpoint_descriptors_bench;
    import uied_pkg::*;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic [15:0] reg_addr = 16'h0000;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    uied_req_type bm_req;
    uied_ans_type bm_ans;
    logic irq;
    int fails = 0;
    int checks_done = 0;

    always #4 ref_clk = ~ref_clk;

    uied_descriptors #(.EP_COUNT(3)) dut_u (
        .ref_clk(ref_clk),
        .srst(srst),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .bm_req(bm_req),
        .bm_ans(bm_ans),
        .irq(irq)
    );

    uied_bm_model model_u (.ref_clk(ref_clk), .bm_req(bm_req));

    task automatic chk_reg(input string what, input logic [7:0] exp,
                           input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_ans(input string what, input logic [15:0] exp,
                           input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rdc(input logic [15:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        chk_reg($sformatf("reg %h", a), exp, reg_rdata);
    endtask

    task automatic stop_test();
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (4000) @(posedge ref_clk);
        fails++;
        stop_test();
    end

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        logic [15:0] w;
        repeat (16) @(posedge ref_clk);
        srst <= 1'b0;
        rdc(16'hFF80, 8'h00);
        rdc(16'hFF81, 8'h80);
        rdc(16'hFF13, 8'h80);
        rdc(16'hFFF0, 8'h00);
        $display("test reset done");

        wr(16'hFF00, 8'h40);
        rdc(16'hFF00, 8'h40);
        wr(16'hFF04, 8'hFF);
        rdc(16'hFF04, 8'h7F);
        wr(16'hFF80, 8'hFF);
        rdc(16'hFF80, 8'h8C);
        wr(16'hFF81, 8'hFF);
        rdc(16'hFF81, 8'h8F);
        wr(16'hFF82, 8'h5A);
        rdc(16'hFF82, 8'h08);
        wr(16'hFF83, 8'hA5);
        rdc(16'hFF83, 8'h85);
        $display("test fields done");

        for (int n = 1; n <= 3; n++) begin
            w = 16'hFF00 + 16'((n - 1) * 8);
            wr(w + 16'h0001, 8'h10 + 8'(n));
            wr(w + 16'h0004, 8'h40);
            wr(w + 16'h0005, 8'h80);
            wr(w, 8'h05);
            model_u.serve(2'(n), 7'h3F);
            chk_ans("addr", {5'h00, 8'h10 + 8'(n), 3'h0} + 16'h003F,
                    bm_ans.addr);
            chk_ans("in range", 16'h0001, bm_ans.in_range);
            chk_ans("nak", 16'h0000, bm_ans.nak);
            chk_ans("count", 16'h0005, bm_ans.count);
            chk_ans("count ok", 16'h0001, bm_ans.count_ok);
            chk_ans("enable", 16'h0001, bm_ans.enable);
            model_u.serve(2'(n), 7'h40);
            chk_ans("out range", 16'h0000, bm_ans.in_range);
        end
        $display("test address done");

        wr(16'hFF02, 8'h20);
        wr(16'hFF05, 8'h94);
        wr(16'hFF89, 8'h02);
        model_u.serve(2'h1, 7'h00);
        chk_ans("x addr", 16'h0088, bm_ans.addr);
        model_u.pulse_done();
        model_u.serve(2'h1, 7'h02);
        chk_ans("y addr", 16'h0102, bm_ans.addr);
        chk_ans("y nak", 16'h0001, bm_ans.nak);
        rdc(16'hFF00, 8'h85);
        rdc(16'hFF01, 8'h11);
        rdc(16'hFF02, 8'h20);
        rdc(16'hFF05, 8'hB4);
        chk_ans("irq ep1", 16'h0001, irq);
        wr(16'hFF8A, 8'h02);
        rdc(16'hFF88, 8'h00);
        $display("test double buffer done");

        wr(16'hFF80, 8'h84);
        wr(16'hFF89, 8'h01);
        wr(16'hFF81, 8'h03);
        model_u.serve(2'h0, 7'h07);
        chk_ans("ep0 addr", 16'hFEFF, bm_ans.addr);
        chk_ans("out base", 16'hFEF0, bm_ans.out_base);
        chk_ans("ep0 enable", 16'h0001, bm_ans.enable);
        chk_ans("ep0 range", 16'h0001, bm_ans.in_range);
        model_u.pulse_done();
        rdc(16'hFF88, 8'h01);
        chk_ans("irq set", 16'h0001, irq);
        rdc(16'hFF80, 8'hA4);
        rdc(16'hFF81, 8'h83);
        wr(16'hFF8A, 8'h01);
        rdc(16'hFF88, 8'h00);
        chk_ans("irq clear", 16'h0000, irq);
        wr(16'hFF80, 8'h80);
        model_u.pulse_done();
        rdc(16'hFF88, 8'h00);
        rdc(16'hFF80, 8'h80);
        wr(16'hFF89, 8'h00);
        wr(16'hFF80, 8'h84);
        model_u.pulse_done();
        rdc(16'hFF88, 8'h01);
        chk_ans("irq masked", 16'h0000, irq);
        wr(16'hFF8A, 8'h01);
        wr(16'hFF80, 8'h00);
        model_u.serve(2'h0, 7'h00);
        chk_ans("ep0 off", 16'h0000, bm_ans.enable);
        $display("test endpoint zero done");

        wr(16'hFF80, 8'h08);
        rdc(16'hFF80, 8'h28);
        model_u.serve(2'h0, 7'h00);
        chk_ans("stall", 16'h0001, bm_ans.stall);
        model_u.pulse_setup();
        model_u.serve(2'h0, 7'h00);
        chk_ans("stall clr", 16'h0000, bm_ans.stall);
        $display("test stall done");
        stop_test();
    end
endmodule
